//--- design/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Counter width and reset value of the programmed timeout
`define WDT_CNT_W 32
`define WDT_LOAD_RST 32'hFFFFFFFF

// Control word fields
`define WDT_CTRL_W 2
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_RESEN_BIT 1
`define WDT_CTRL_RST 2'h0

// Lock key: writing this value opens the lock, any other value closes it
// Key value is arbitrary
`define WDT_UNLOCK_KEY 32'hA5A5A5A5
`define WDT_LOCK_RST 1'b0

// Clock rate and derived timing
`define WDT_CLK_MHZ 25
`define WDT_DEC_DIV 1
`define WDT_RST_HOLD_NS 1000
`define WDT_RST_HOLD_CYC ((`WDT_RST_HOLD_NS * `WDT_CLK_MHZ + 999) / 1000)

`endif

//--- design/wdt_pkg.sv
package wdt_pkg;

	// One write request carried with its data
	typedef struct packed {
		logic we;
		logic [31:0] data;
	} wdt_wr_t;

	// Timeout sequencer states, Gray along idle, pending, reset
	typedef enum logic [1:0] {
		WDT_IDLE = 2'h0,
		WDT_PEND = 2'h1,
		WDT_RST = 2'h3
	} wdt_state_t;

endpackage : wdt_pkg

//--- design/wdt_cnt.sv
`timescale 1ns/1ps
`default_nettype none

// Loadable down counter
module wdt_cnt #(
	parameter int W = 32
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	input wire logic dec_i,
	output logic [W-1:0] cnt_o,
	output logic zero_o
);

	logic [W-1:0] cnt_q; // Current count

	// Load has priority over decrement
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= '1;
		end else if (load_i) begin
			cnt_q <= load_val_i; // [R1]
		end else if (dec_i) begin
			cnt_q <= cnt_q - W'(1); // [R1]
		end
	end

	assign cnt_o = cnt_q;
	assign zero_o = (cnt_q == '0);

endmodule : wdt_cnt

`default_nettype wire

//--- design/wdt_core.sv
// Overview of operation
// R1 - 32-bit down counter loaded with programmed timeout
// R2 - Every timeout raises the interrupt request, except one during WDT_RST, which is ignored
// R3 - Timeout with interrupt still pending asserts reset
// R4 - Engaged lock blocks writes to other controls
// R5 - Counter decrements on oscillator-derived watchdog tick
// R6 - Refresh reloads counter and clears pending interrupt
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module wdt_core #(
	parameter int unsigned DEC_DIV = `WDT_DEC_DIV,
	parameter int unsigned RST_HOLD = `WDT_RST_HOLD_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire wdt_pkg::wdt_wr_t load_wr_i,
	input wire wdt_pkg::wdt_wr_t ctrl_wr_i,
	input wire wdt_pkg::wdt_wr_t lock_wr_i,
	input wire logic refresh_i,
	input wire logic int_clr_i,
	output logic irq_o,
	output logic sys_rst_o,
	output logic locked_o,
	output logic [`WDT_CNT_W-1:0] count_o,
	output logic [`WDT_CTRL_W-1:0] ctrl_o
);

	localparam int DIV_W = 16; // Width of the tick divider

	// Programmed state
	logic lock_q; // Lock engaged
	logic [`WDT_CNT_W-1:0] load_q; // Programmed timeout
	logic [`WDT_CTRL_W-1:0] ctrl_q; // Enable and reset enable

	// Tick divider
	logic [DIV_W-1:0] div_q;
	logic tick_q; // One-cycle decrement enable

	// Sequencer
	wdt_pkg::wdt_state_t state_q, state_d;
	logic [15:0] hold_q; // Reset pulse length counter
	logic irq_q;
	logic rst_q;

	// Counter interface
	logic [`WDT_CNT_W-1:0] cnt;
	logic cnt_zero;
	logic cnt_load;
	logic [`WDT_CNT_W-1:0] cnt_load_val;
	logic cnt_dec;

	// Qualified requests
	logic wr_ok;
	logic load_ok;
	logic ctrl_ok;
	logic refresh_ok;
	logic clr_ok;
	logic en;
	logic resen;
	logic timeout;
	logic hold_done;

	// Lock gates every control write except the lock itself
	assign wr_ok = !lock_q; // [R4]
	assign load_ok = load_wr_i.we && wr_ok; // [R4]
	assign ctrl_ok = ctrl_wr_i.we && wr_ok; // [R4]
	assign refresh_ok = refresh_i && wr_ok; // [R4]
	assign clr_ok = (int_clr_i && wr_ok) || refresh_ok; // [R6]

	assign en = ctrl_q[`WDT_CTRL_EN_BIT];
	assign resen = ctrl_q[`WDT_CTRL_RESEN_BIT];

	// Expiry is a tick seen while the count stands at zero
	assign timeout = tick_q && en && cnt_zero; // [R2]
	assign hold_done = (hold_q == 16'h0001);

	// Reload on timeout write, refresh or expiry; new timeout wins
	assign cnt_load = load_ok || refresh_ok || timeout; // [R6]
	assign cnt_load_val = load_ok ? load_wr_i.data : load_q; // [R1]
	assign cnt_dec = tick_q && en && !cnt_zero; // [R5]

	// Lock register, always writable
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lock_q <= `WDT_LOCK_RST;
		end else if (lock_wr_i.we) begin
			// Any value but the key engages the lock
			lock_q <= (lock_wr_i.data != `WDT_UNLOCK_KEY); // [R4]
		end
	end

	// Timeout value register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			load_q <= `WDT_LOAD_RST;
		end else if (load_ok) begin
			load_q <= load_wr_i.data; // [R1]
		end
	end

	// Control register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q <= `WDT_CTRL_RST;
		end else if (ctrl_ok) begin
			ctrl_q <= ctrl_wr_i.data[`WDT_CTRL_W-1:0]; // [R4]
		end
	end

	// Divider from the oscillator clock to the decrement tick
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_q >= DIV_W'(DEC_DIV - 1)) begin
			// Wrap and issue one tick
			div_q <= 16'h0000;
			tick_q <= 1'b1; // [R5]
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// Down counter
	wdt_cnt #(
		.W(`WDT_CNT_W)
	) u_cnt (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.load_i(cnt_load),
		.load_val_i(cnt_load_val),
		.dec_i(cnt_dec),
		.cnt_o(cnt),
		.zero_o(cnt_zero)
	);

	// Sequencer next state; an expiry blocks a same-cycle clear, which in turn blocks the reset of that expiry
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			wdt_pkg::WDT_IDLE: begin
				// First expiry only raises the interrupt
				if (timeout) begin
					state_d = wdt_pkg::WDT_PEND; // [R2]
				end
			end
			wdt_pkg::WDT_PEND: begin
				if (timeout && !clr_ok && resen) begin
					// Second expiry while still unserviced
					state_d = wdt_pkg::WDT_RST; // [R3]
				end else if (clr_ok && !timeout) begin
					// Serviced in time
					state_d = wdt_pkg::WDT_IDLE; // [R6]
				end
			end
			wdt_pkg::WDT_RST: begin
				// Release after the hold time
				if (hold_done) begin
					state_d = wdt_pkg::WDT_IDLE;
				end
			end
			default: begin
				state_d = wdt_pkg::WDT_IDLE;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= wdt_pkg::WDT_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Reset pulse length
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hold_q <= 16'h0000;
		end else if (state_q != wdt_pkg::WDT_RST && state_d == wdt_pkg::WDT_RST) begin
			hold_q <= 16'(RST_HOLD); // [R3]
		end else if (hold_q != 16'h0000) begin
			hold_q <= hold_q - 16'h0001;
		end
	end

	// Registered interrupt and reset outputs
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			irq_q <= (state_d != wdt_pkg::WDT_IDLE); // [R2]
			rst_q <= (state_d == wdt_pkg::WDT_RST); // [R3]
		end
	end

	// Counter value mirror for the output
	logic [`WDT_CNT_W-1:0] count_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_q <= '1;
		end else begin
			count_q <= cnt;
		end
	end

	assign irq_o = irq_q;
	assign sys_rst_o = rst_q;
	assign locked_o = lock_q;
	assign count_o = count_q;
	assign ctrl_o = ctrl_q;

endmodule : wdt_core

`default_nettype wire

//--- test/wdt_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
// Watches the watchdog core ports
module wdt_core_chk (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire wdt_pkg::wdt_wr_t load_wr_i,
	input wire wdt_pkg::wdt_wr_t ctrl_wr_i,
	input wire wdt_pkg::wdt_wr_t lock_wr_i,
	input wire logic refresh_i,
	input wire logic int_clr_i,
	input wire logic irq_o,
	input wire logic sys_rst_o,
	input wire logic locked_o,
	input wire logic [31:0] count_o,
	input wire logic [1:0] ctrl_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// Reset pulse of two cycles, then low
	sequence rst_pulse_s;
		sys_rst_o[*2] ##1 !sys_rst_o;
	endsequence
	lock_key_a: assert property (lock_wr_i.we |=>
		locked_o == ($past(lock_wr_i.data) != `WDT_UNLOCK_KEY)) else $error("lock");
	ctrl_wr_a: assert property (!locked_o && ctrl_wr_i.we |=>
		ctrl_o == $past(ctrl_wr_i.data[1:0])) else $error("ctrl write");
	ctrl_hold_a: assert property (locked_o[*2] |=> $stable(ctrl_o))
		else $error("ctrl hold");
	cnt_dec_a: assert property ($past(ctrl_o[0]) && count_o != 0 && !$past(refresh_i)
		&& !$past(load_wr_i.we) |=> count_o == $past(count_o) - 1) else $error("step");
	irq_to_a: assert property (ctrl_o[0] && count_o == 0 |-> ##[0:2] irq_o)
		else $error("irq");
	rst_pend_a: assert property ($rose(sys_rst_o) |-> $past(irq_o) && $past(ctrl_o[1]))
		else $error("rst cause");
	lock_clr_a: assert property (locked_o && irq_o && !sys_rst_o |=> irq_o)
		else $error("lock clear");
	rst_len_a: assert property ($rose(sys_rst_o) |-> rst_pulse_s)
		else $error("rst len");
	clr_a: assert property (!locked_o && (refresh_i || int_clr_i) && !sys_rst_o
		&& count_o > 2 |=> !irq_o) else $error("clear");
endmodule : wdt_core_chk
bind wdt_core wdt_core_chk chk_u (.clk_i, .nrst_i, .load_wr_i, .ctrl_wr_i, .lock_wr_i,
	.refresh_i, .int_clr_i, .irq_o, .sys_rst_o, .locked_o, .count_o, .ctrl_o);
`default_nettype wire

//--- test/wdt_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module wdt_core_tb_top;
	logic clk_i = 0, nrst_i = 0, refresh_i = 0, int_clr_i = 0;
	logic irq_o, sys_rst_o, locked_o;
	logic [1:0] ctrl_o;
	logic [31:0] count_o, t, meas, rs = 32'h5E86;
	logic [35:0] q[$]; // Notes: kind, expected
	wdt_pkg::wdt_wr_t load_wr_i = '0, ctrl_wr_i = '0, lock_wr_i = '0;
	int fails = 0, cmp_count = 0;
	string nm[6] = '{"cnt", "ctl", "lck", "irq", "rst", "cyc"};
	event note_e;
	always #20 clk_i = ~clk_i;
	wdt_core #(.RST_HOLD(2)) dut_u (.clk_i, .nrst_i, .load_wr_i, .ctrl_wr_i, .lock_wr_i,
		.refresh_i, .int_clr_i, .irq_o, .sys_rst_o, .locked_o, .count_o, .ctrl_o);
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd
	// Result of the given kind
	function automatic logic [31:0] pick(input logic [3:0] k);
		logic [31:0] v[6];
		v = '{count_o, 32'(ctrl_o), 32'(locked_o), 32'(irq_o), 32'(sys_rst_o), meas};
		return v[k];
	endfunction : pick
	task automatic print_verdict();
		$display("Compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic note(input logic [3:0] k, input logic [31:0] e);
		q.push_back({k, e});
		->note_e;
	endtask : note
	// Checker side: oldest note against the output
	always begin
		@(note_e);
		while (q.size() > 0) begin
			cmp_count++;
			if (pick(q[0][35:32]) !== q[0][31:0]) begin
				fails++;
				$display("[ERR] %s exp %h got %h", nm[q[0][35:32]], q[0][31:0], pick(q[0][35:32]));
			end
			void'(q.pop_front());
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc
	task automatic wr(ref wdt_pkg::wdt_wr_t w, input logic [31:0] d);
		w = {1'b1, d};
		cyc(1);
		w.we = 0;
		cyc(1);
	endtask : wr
	task automatic pulse(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
		cyc(1);
	endtask : pulse
	// Bounded wait for a high result, cycles in meas
	task automatic wait_hi(input logic [3:0] k);
		int n;
		n = 0;
		while (pick(k) !== 1) begin
			cyc(1);
			n++;
			if (n > 99) begin
				fails++;
				print_verdict();
			end
		end
		// Set only at the end so a pending cycle note still reads its own count
		meas = n;
	endtask : wait_hi
	initial begin
		t = 32'h6 + (rnd() & 32'h7);
		cyc(8);
		nrst_i = 1;
		cyc(1);
		note(0, 32'hFFFFFFFF);
		note(2, 0);
		wr(ctrl_wr_i, rnd() | 32'h3);
		note(1, 3);
		wr(load_wr_i, t);
		wait_hi(3);
		note(5, t);
		wait_hi(4);
		note(5, t + 1);
		cyc(3);
		note(4, 0);
		repeat (4) begin
			pulse(refresh_i);
			note(0, t);
			note(3, 0);
			cyc(t - 4);
		end
		wr(lock_wr_i, rnd() & 32'hFFFF);
		note(2, 1);
		pulse(refresh_i);
		wr(ctrl_wr_i, 0);
		note(1, 3);
		pulse(int_clr_i);
		wait_hi(4);
		cyc(3);
		wr(lock_wr_i, `WDT_UNLOCK_KEY);
		note(2, 0);
		wait_hi(3);
		cyc(2);
		pulse(int_clr_i);
		note(3, 0);
		wait_hi(3);
		note(5, t - 3);
		note(4, 0);
		cyc(2);
		print_verdict();
	end
endmodule : wdt_core_tb_top
`default_nettype wire
